// *** verilog/hts_pkg.sv ***
// Constants shared by the hybrid tap and on-hook speed register bank.
// Assumes a 50 MHz reference clock and word-aligned Wishbone addressing.
package hts_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [5:0] HTS_IDX_TAP_SEVEN = 6'h33;
  localparam logic [5:0] HTS_IDX_TAP_EIGHT = 6'h34;
  localparam logic [5:0] HTS_IDX_RSVD_LO   = 6'h35;
  localparam logic [5:0] HTS_IDX_RSVD_HI   = 6'h3A;
  localparam logic [5:0] HTS_IDX_SPEED_CTL = 6'h3B;
  localparam logic [5:0] HTS_IDX_HOOK_CTL  = 6'h3C;
  localparam logic [5:0] HTS_IDX_HOOK_STAT = 6'h3D;

  // Reset values.
  localparam logic [7:0] HTS_RST_TAP       = 8'h00;
  localparam logic [7:0] HTS_RST_SPEED     = 8'h00;
  localparam logic [2:0] HTS_RST_HOOK      = 3'h0;

  // Speed control field positions and writable mask.
  localparam int         HTS_SPD_QHI       = 6;
  localparam int         HTS_SPD_QLO       = 4;
  localparam int         HTS_SPD_RXG       = 2;
  localparam int         HTS_SPD_GCE       = 1;
  localparam logic [7:0] HTS_SPD_MASK      = 8'h56;

  // Hook control field positions.
  localparam int         HTS_HC_OFFHOOK    = 0;
  localparam int         HTS_HC_PRIMARY    = 1;
  localparam int         HTS_HC_SECONDARY  = 2;

  // Hook status field positions.
  localparam int         HTS_HS_LOOP       = 0;
  localparam int         HTS_HS_BUSY       = 1;
  localparam int         HTS_HS_UNSUP      = 2;

  // Release timing.
  localparam int         HTS_CLK_MHZ       = 50;
  localparam int         HTS_FAST_US       = 400;
  localparam int         HTS_ETSI_US       = 3000;
  localparam int         HTS_QUENCH_US     = 26000;
  localparam int         HTS_FAST_CYC      = HTS_FAST_US * HTS_CLK_MHZ;
  localparam int         HTS_ETSI_CYC      = HTS_ETSI_US * HTS_CLK_MHZ;
  localparam int         HTS_QUENCH_CYC    = HTS_QUENCH_US * HTS_CLK_MHZ;
  localparam int         HTS_CNT_W         = 21;

endpackage : hts_pkg

// *** verilog/hts_hook_if.sv ***
// Link between the register bank and the on-hook release timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface hts_hook_if;
  logic       offhook;
  logic       speed_primary;
  logic       speed_secondary;
  logic [1:0] quench_sel;
  logic       loop_on;
  logic       busy;
  logic       unsupported;

  modport ctl (output offhook, output speed_primary, output speed_secondary,
               output quench_sel, input loop_on, input busy, input unsupported);
  modport tmr (input offhook, input speed_primary, input speed_secondary,
               input quench_sel, output loop_on, output busy, output unsupported);
endinterface : hts_hook_if

// *** verilog/hts_hook_timer.sv ***
// On-hook release timer: holds loop current for the selected time after hook release.
// Assumes its controls come from registers on the same clock.
`timescale 1ns/10ps
module hts_hook_timer
  import hts_pkg::*;
#(
  parameter int CW         = HTS_CNT_W,
  parameter int FAST_CYC   = HTS_FAST_CYC,
  parameter int ETSI_CYC   = HTS_ETSI_CYC,
  parameter int QUENCH_CYC = HTS_QUENCH_CYC
)
(
  // Clock and reset.
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // Register side.
  hts_hook_if.tmr   hk
);

  typedef struct packed {
    logic          loop_on;
    logic          prev_oh;
    logic [CW-1:0] cnt;
  } hts_tmr_t;

  hts_tmr_t      s_r;
  hts_tmr_t      s_nxt;
  logic          start;
  logic          sel_fast;
  logic          sel_etsi;
  logic          sel_quench;
  logic [CW-1:0] dur;

  always_comb
  begin
    sel_fast   = !hk.speed_primary && !hk.speed_secondary && hk.quench_sel == 2'b00;
    sel_etsi   = !hk.speed_primary && hk.speed_secondary && hk.quench_sel == 2'b00;
    sel_quench = hk.speed_primary && hk.quench_sel == 2'b11;
    if (sel_quench)
      dur = CW'(QUENCH_CYC);
    else if (sel_etsi)
      dur = CW'(ETSI_CYC);
    else
      dur = CW'(FAST_CYC);
    start = s_r.prev_oh && !hk.offhook && s_r.loop_on;
    s_nxt = s_r;
    s_nxt.prev_oh = hk.offhook;
    if (hk.offhook)
    begin
      s_nxt.loop_on = 1'b1;
      s_nxt.cnt     = '0;
    end
    else if (start)
      s_nxt.cnt = dur;
    else if (s_r.cnt != '0)
    begin
      s_nxt.cnt = s_r.cnt - CW'(1);
      if (s_r.cnt == CW'(1))
        s_nxt.loop_on = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign hk.loop_on     = s_r.loop_on;
  assign hk.busy        = s_r.cnt != '0;
  assign hk.unsupported = !(sel_fast || sel_etsi || sel_quench);

  property p_fast_load;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      start && sel_fast |=> s_r.cnt == CW'(FAST_CYC) && s_r.loop_on;
  endproperty
  a_fast_load : assert property (p_fast_load)
    else $error("fast release not loaded");

  property p_etsi_load;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      start && sel_etsi |=> s_r.cnt == CW'(ETSI_CYC);
  endproperty
  a_etsi_load : assert property (p_etsi_load)
    else $error("three ms release not loaded");

  property p_quench_load;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      start && sel_quench |=> s_r.cnt == CW'(QUENCH_CYC);
  endproperty
  a_quench_load : assert property (p_quench_load)
    else $error("quench release not loaded");

  property p_unsup;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      start && hk.unsupported |=> s_r.cnt == CW'(FAST_CYC);
  endproperty
  a_unsup : assert property (p_unsup)
    else $error("unsupported combination not on fast time");

  property p_count;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      s_r.cnt > CW'(1) && !hk.offhook |=> s_r.cnt == $past(s_r.cnt) - CW'(1) && s_r.loop_on;
  endproperty
  a_count : assert property (p_count)
    else $error("release count not stepping");

  property p_drop;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      s_r.cnt == CW'(1) && !hk.offhook |=> !s_r.loop_on ##1 !s_r.loop_on;
  endproperty
  a_drop : assert property (p_drop)
    else $error("loop current not released at end of count");

endmodule : hts_hook_timer

// *** verilog/hts_regs_top.sv ***
// Register bank for hybrid taps seven and eight and the on-hook speed control.
// Assumes a classic Wishbone master on i_ref_clk and 32-bit word addressing.
`timescale 1ns/10ps
module hts_regs_top
  import hts_pkg::*;
#(
  parameter int CW         = HTS_CNT_W,
  parameter int FAST_CYC   = HTS_FAST_CYC,
  parameter int ETSI_CYC   = HTS_ETSI_CYC,
  parameter int QUENCH_CYC = HTS_QUENCH_CYC
)
(
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // Wishbone slave.
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Hybrid filter coefficients.
  output logic      [7:0]  o_tap_seven_coeff,
  output logic      [7:0]  o_tap_eight_coeff,
  output logic      [1:0]  o_tap_active,
  // Line-side controls.
  output logic             o_offhook_ctrl,
  output logic             o_loop_current_on,
  output logic             o_rx_gain_boost,
  output logic             o_guarded_clear_en
);

  typedef struct packed {
    logic [7:0] tap_seven;
    logic [7:0] tap_eight;
    logic [1:0] tap_act;
    logic [7:0] speed;
    logic [2:0] hook;
    logic       ack;
    logic [7:0] rdata;
  } hts_regs_t;

  hts_regs_t  s_r;
  hts_regs_t  s_nxt;
  logic [5:0] idx;
  logic       wr;
  logic [7:0] wdat;
  logic [7:0] stat;

  hts_hook_if hk ();

  hts_hook_timer #(
    .CW         (CW),
    .FAST_CYC   (FAST_CYC),
    .ETSI_CYC   (ETSI_CYC),
    .QUENCH_CYC (QUENCH_CYC)
  ) i_hts_hook_timer (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .hk        (hk.tmr)
  );

  assign hk.offhook         = s_r.hook[HTS_HC_OFFHOOK];
  assign hk.speed_primary   = s_r.hook[HTS_HC_PRIMARY];
  assign hk.speed_secondary = s_r.hook[HTS_HC_SECONDARY];
  assign hk.quench_sel      = {s_r.speed[HTS_SPD_QHI], s_r.speed[HTS_SPD_QLO]};

  always_comb
  begin
    idx  = i_wb_adr[7:2];
    wdat = i_wb_dat[7:0];
    stat = 8'h00;
    stat[HTS_HS_LOOP]  = hk.loop_on;
    stat[HTS_HS_BUSY]  = hk.busy;
    stat[HTS_HS_UNSUP] = hk.unsupported;
    s_nxt = s_r;
    s_nxt.ack = i_wb_cyc && i_wb_stb && !s_r.ack;
    wr = s_nxt.ack && i_wb_we && i_wb_sel[0];
    if (wr)
    begin
      case (idx)
        HTS_IDX_TAP_SEVEN: s_nxt.tap_seven = wdat;
        HTS_IDX_TAP_EIGHT: s_nxt.tap_eight = wdat;
        // Bit 7 and the other unnamed bits stay zero whatever is written.
        HTS_IDX_SPEED_CTL: s_nxt.speed = wdat & HTS_SPD_MASK;
        HTS_IDX_HOOK_CTL:  s_nxt.hook  = wdat[2:0];
        // The reserved range and unmapped words ignore writes.
        default:           s_nxt.hook  = s_r.hook;
      endcase
    end
    s_nxt.tap_act[0] = s_nxt.tap_seven != 8'h00;
    s_nxt.tap_act[1] = s_nxt.tap_eight != 8'h00;
    if (s_nxt.ack && !i_wb_we)
    begin
      case (idx)
        HTS_IDX_TAP_SEVEN: s_nxt.rdata = s_r.tap_seven;
        HTS_IDX_TAP_EIGHT: s_nxt.rdata = s_r.tap_eight;
        HTS_IDX_SPEED_CTL: s_nxt.rdata = s_r.speed;
        HTS_IDX_HOOK_CTL:  s_nxt.rdata = {5'h00, s_r.hook};
        HTS_IDX_HOOK_STAT: s_nxt.rdata = stat;
        default:           s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_r           <= '0;
      s_r.tap_seven <= HTS_RST_TAP;
      s_r.tap_eight <= HTS_RST_TAP;
      s_r.speed     <= HTS_RST_SPEED;
      s_r.hook      <= HTS_RST_HOOK;
    end
    else
      s_r <= s_nxt;
  end

  assign o_wb_dat           = {24'h000000, s_r.rdata};
  assign o_wb_ack           = s_r.ack;
  assign o_tap_seven_coeff  = s_r.tap_seven;
  assign o_tap_eight_coeff  = s_r.tap_eight;
  assign o_tap_active       = s_r.tap_act;
  assign o_offhook_ctrl     = s_r.hook[HTS_HC_OFFHOOK];
  assign o_loop_current_on  = hk.loop_on;
  assign o_rx_gain_boost    = s_r.speed[HTS_SPD_RXG];
  assign o_guarded_clear_en = s_r.speed[HTS_SPD_GCE];

  property p_tap_seven_wr;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && idx == HTS_IDX_TAP_SEVEN
      |=> o_tap_seven_coeff == $past(i_wb_dat[7:0]) && o_wb_ack;
  endproperty
  a_tap_seven_wr : assert property (p_tap_seven_wr)
    else $error("tap seven write lost");

  property p_tap_eight_rd;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && idx == HTS_IDX_TAP_EIGHT
      |=> o_wb_ack && o_wb_dat[7:0] == $past(o_tap_eight_coeff);
  endproperty
  a_tap_eight_rd : assert property (p_tap_eight_rd)
    else $error("tap eight read back wrong");

  property p_tap_zero;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      o_tap_active == {o_tap_eight_coeff != 8'h00, o_tap_seven_coeff != 8'h00};
  endproperty
  a_tap_zero : assert property (p_tap_zero)
    else $error("tap activity does not follow coefficient");

  property p_speed_top_zero;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      o_wb_ack && $past(idx) == HTS_IDX_SPEED_CTL && !$past(i_wb_we) |-> !o_wb_dat[7];
  endproperty
  a_speed_top_zero : assert property (p_speed_top_zero)
    else $error("reserved speed bit reads one");

  property p_quench_route;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && idx == HTS_IDX_SPEED_CTL
      |=> hk.quench_sel == {$past(i_wb_dat[6]), $past(i_wb_dat[4])};
  endproperty
  a_quench_route : assert property (p_quench_route)
    else $error("quench selection not routed");

  property p_release_start;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      $fell(o_offhook_ctrl) && o_loop_current_on |=> ##1 hk.busy && o_loop_current_on;
  endproperty
  a_release_start : assert property (p_release_start)
    else $error("release did not start after hook clear");

  property p_ack_pulse;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse : assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  property p_ack_answer;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_answer : assert property (p_ack_answer)
    else $error("request not acknowledged in one cycle");

  property p_ack_idle;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack;
  endproperty
  a_ack_idle : assert property (p_ack_idle)
    else $error("ack without a request");

  property p_tap_eight_wr;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && idx == HTS_IDX_TAP_EIGHT
      |=> o_tap_eight_coeff == $past(i_wb_dat[7:0]) && o_wb_ack;
  endproperty
  a_tap_eight_wr : assert property (p_tap_eight_wr)
    else $error("tap eight write lost");

  property p_tap_seven_rd;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && idx == HTS_IDX_TAP_SEVEN
      |=> o_wb_ack && o_wb_dat[7:0] == $past(o_tap_seven_coeff);
  endproperty
  a_tap_seven_rd : assert property (p_tap_seven_rd)
    else $error("tap seven read back wrong");

  // A write whose low byte lane is off must leave both tap registers and the speed register alone.
  property p_lane_off;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && !i_wb_sel[0]
      |=> $stable(o_tap_seven_coeff) && $stable(o_tap_eight_coeff) && $stable(s_r.speed);
  endproperty
  a_lane_off : assert property (p_lane_off)
    else $error("write with low lane off changed a register");

  // Writes outside the four writable words change nothing.
  property p_unmapped_wr;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && idx != HTS_IDX_TAP_SEVEN
      && idx != HTS_IDX_TAP_EIGHT && idx != HTS_IDX_SPEED_CTL && idx != HTS_IDX_HOOK_CTL
      |=> $stable(o_tap_seven_coeff) && $stable(o_tap_eight_coeff)
      && $stable(s_r.speed) && $stable(s_r.hook);
  endproperty
  a_unmapped_wr : assert property (p_unmapped_wr)
    else $error("write outside the writable words changed a register");

  property p_speed_mask;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (s_r.speed & ~HTS_SPD_MASK) == 8'h00;
  endproperty
  a_speed_mask : assert property (p_speed_mask)
    else $error("unnamed speed bit set");

  property p_speed_route;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && idx == HTS_IDX_SPEED_CTL
      |=> o_rx_gain_boost == $past(i_wb_dat[2]) && o_guarded_clear_en == $past(i_wb_dat[1]);
  endproperty
  a_speed_route : assert property (p_speed_route)
    else $error("gain or guarded clear bit not routed");

  property p_hook_route;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && idx == HTS_IDX_HOOK_CTL
      |=> {hk.speed_secondary, hk.speed_primary, o_offhook_ctrl} == $past(i_wb_dat[2:0]);
  endproperty
  a_hook_route : assert property (p_hook_route)
    else $error("hook control not routed");

  property p_loop_hold;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      o_offhook_ctrl |=> o_loop_current_on;
  endproperty
  a_loop_hold : assert property (p_loop_hold)
    else $error("loop current off while off-hook");

  property p_rd_upper;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      o_wb_ack |-> o_wb_dat[31:8] == 24'h000000;
  endproperty
  a_rd_upper : assert property (p_rd_upper)
    else $error("read data above the low byte");

  property p_rd_hold;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !(i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we) |=> $stable(o_wb_dat);
  endproperty
  a_rd_hold : assert property (p_rd_hold)
    else $error("read data changed without a read");

  property p_rsvd_rd;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && idx >= HTS_IDX_RSVD_LO
      && idx <= HTS_IDX_RSVD_HI |=> o_wb_ack && o_wb_dat == 32'h00000000;
  endproperty
  a_rsvd_rd : assert property (p_rsvd_rd)
    else $error("reserved word does not read zero");

  property p_status_rd;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && idx == HTS_IDX_HOOK_STAT
      |=> o_wb_dat[HTS_HS_UNSUP] == $past(hk.unsupported)
      && o_wb_dat[HTS_HS_BUSY] == $past(hk.busy)
      && o_wb_dat[HTS_HS_LOOP] == $past(o_loop_current_on);
  endproperty
  a_status_rd : assert property (p_status_rd)
    else $error("hook status read back wrong");

endmodule : hts_regs_top

// *** sim/hybrid_taps_onhook_speed_regs_tb.sv ***
// Self-checking bench for the hybrid tap and on-hook speed register bank.
// Assumes hts_regs_top with short release counts and a classic Wishbone slave.
`timescale 1ns/10ps
module hybrid_taps_onhook_speed_regs_tb
  import hts_pkg::*;
;
  localparam int FAST   = 5;
  localparam int ETSI   = 10;
  localparam int QUENCH = 20;

  logic        i_ref_clk;
  logic        i_resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  tap7;
  logic [7:0]  tap8;
  logic [1:0]  act;
  logic        offhook;
  logic        loop_on;
  logic        rxg;
  logic        gce;
  int          fail_count = 0;
  int          checked = 0;
  logic [31:0] exp_q[$];
  logic [31:0] rng = 32'hB1DB2115;

  hts_regs_top #(.CW(21), .FAST_CYC(FAST), .ETSI_CYC(ETSI), .QUENCH_CYC(QUENCH))
  i_hts_regs_top (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_tap_seven_coeff(tap7), .o_tap_eight_coeff(tap8),
    .o_tap_active(act), .o_offhook_ctrl(offhook), .o_loop_current_on(loop_on),
    .o_rx_gain_boost(rxg), .o_guarded_clear_en(gce));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv)
    begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
      fail_count++;
    end
  endtask : check

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    rng = lfsr_next(rng);
    @(posedge i_ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {rng[31:8], d};
    sel  <= s;
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, idx, 8'h00, 4'hF);
  endtask : rd

  // Read data is compared against the oldest expectation at each read ack.
  always @(posedge i_ref_clk)
    if (ack === 1'b1 && we === 1'b0)
      check(rdat, exp_q.pop_front());

  task automatic release_run(input logic p, input logic s, input logic [1:0] q,
                             input int d, input logic u);
    int n;
    wb(1'b1, HTS_IDX_SPEED_CTL, {1'b0, q[1], 1'b0, q[0], 4'h0}, 4'h1);
    wb(1'b1, HTS_IDX_HOOK_CTL, {5'h0, s, p, 1'b1}, 4'h1);
    repeat (2) @(posedge i_ref_clk);
    check({30'h0, offhook, loop_on}, 32'h3);
    rd(HTS_IDX_HOOK_CTL, {5'h0, s, p, 1'b1});
    wb(1'b1, HTS_IDX_HOOK_CTL, {5'h0, s, p, 1'b0}, 4'h1);
    #1;
    n = 0;
    while (loop_on === 1'b1 && n < 100)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check(n, d);
    rd(HTS_IDX_HOOK_STAT, {5'h0, u, 2'b00});
  endtask : release_run

  initial
  begin
    #(20 * 20000);
    fail_count++;
    conclude();
  end

  initial
  begin
    logic [7:0] v7;
    logic [7:0] v8;
    i_resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    check({tap7, tap8, act, offhook, loop_on, rxg, gce}, 32'h0);
    rd(HTS_IDX_TAP_SEVEN, HTS_RST_TAP);
    rd(HTS_IDX_TAP_EIGHT, HTS_RST_TAP);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      v7 = (k == 0) ? 8'h00 : rng[7:0];
      v8 = (k == 1) ? 8'h00 : rng[15:8];
      wb(1'b1, HTS_IDX_TAP_SEVEN, v7, 4'h1);
      wb(1'b1, HTS_IDX_TAP_EIGHT, v8, 4'h1);
      wb(1'b1, HTS_IDX_TAP_SEVEN, ~v7, 4'hE);
      check({tap7, tap8}, {16'h0, v7, v8});
      check(act, {30'h0, v8 != 8'h00, v7 != 8'h00});
      rd(HTS_IDX_TAP_SEVEN, v7);
      rd(HTS_IDX_TAP_EIGHT, v8);
    end
    $display("test taps done");
    for (logic [5:0] i = HTS_IDX_RSVD_LO; i <= HTS_IDX_RSVD_HI; i++)
      rd(i, 8'h00);
    wb(1'b1, 6'h00, 8'hFF, 4'h1);
    rd(6'h00, 8'h00);
    wb(1'b1, HTS_IDX_SPEED_CTL, 8'h7F, 4'h1);
    rd(HTS_IDX_SPEED_CTL, HTS_SPD_MASK);
    check({rxg, gce}, 32'h3);
    wb(1'b1, HTS_IDX_SPEED_CTL, 8'h00, 4'h1);
    check({rxg, gce}, 32'h0);
    $display("test map done");
    release_run(1'b0, 1'b0, 2'b00, FAST, 1'b0);
    release_run(1'b0, 1'b1, 2'b00, ETSI, 1'b0);
    release_run(1'b1, 1'b0, 2'b11, QUENCH, 1'b0);
    release_run(1'b1, 1'b1, 2'b11, QUENCH, 1'b0);
    release_run(1'b0, 1'b0, 2'b11, FAST, 1'b1);
    release_run(1'b1, 1'b0, 2'b10, FAST, 1'b1);
    $display("test release done");
    repeat (2) @(posedge i_ref_clk);
    conclude();
  end
endmodule : hybrid_taps_onhook_speed_regs_tb
